// file: verilog/ccl_pkg.sv
// =====================================================================
// Comparator control constants
package ccl_pkg;

  localparam int CCL_NCH = 3;

  // =====================================================================
  // Register map
  localparam logic [7:0] CCL_ADDR_CTRL1 = 8'h00;
  localparam logic [7:0] CCL_ADDR_CTRL2 = 8'h01;
  localparam logic [7:0] CCL_ADDR_CTRL3 = 8'h02;
  localparam logic [7:0] CCL_ADDR_STATUS = 8'h03;
  localparam logic [7:0] CCL_ADDR_FLAGS = 8'h04;

  // Control fields; channel off, events on any change, bandgap selected
  localparam logic [7:0] CCL_CTRL_RST = 8'h1f;
  localparam int CCL_EN_BIT = 7;
  localparam int CCL_OE_BIT = 6;
  localparam int CCL_INV_BIT = 5;
  localparam int CCL_EVT_HI = 4;
  localparam int CCL_EVT_LO = 3;
  localparam int CCL_PREF_BIT = 2;
  localparam int CCL_NSEL_HI = 1;
  localparam int CCL_NSEL_LO = 0;

  localparam logic [7:0] CCL_RD_ZERO = 8'h00;
  localparam logic [4:0] CCL_STAT_PAD = 5'h00;
  localparam logic [2:0] CCL_FLAG_RST = 3'h0;
  localparam logic CCL_RES_RST = 1'b0;

  typedef enum logic [1:0] {
    CCL_EVT_NONE = 2'b00,
    CCL_EVT_RISE = 2'b01,
    CCL_EVT_FALL = 2'b10,
    CCL_EVT_ANY = 2'b11
  } ccl_evt_t;

  typedef enum logic [1:0] {
    CCL_NEG_SHARED_B = 2'b00,
    CCL_NEG_B = 2'b01,
    CCL_NEG_C = 2'b10,
    CCL_NEG_BANDGAP = 2'b11
  } ccl_neg_t;

endpackage

// file: verilog/ccl_chan_if.sv
`timescale 1ns/1ns
// =====================================================================
// Control and result of one comparator channel
interface ccl_chan_if;
  logic [7:0] ctrl;
  logic raw;
  logic result;
  logic evt;
  modport chan (input ctrl, input raw, output result, output evt);
  modport host (output ctrl, output raw, input result, input evt);
endinterface // ccl_chan_if

// file: verilog/ccl_channel.sv
`timescale 1ns/1ns
module ccl_channel (
  input wire logic clk_sys, // System clock
  input wire logic sys_rst, // Async reset, active high
  ccl_chan_if.chan cif // Control in, result and event out
);
  import ccl_pkg::*;

  logic resD;
  logic resQ;
  logic prevQ;
  logic rise;
  logic fall;
  ccl_evt_t evtSel;

  // =====================================================================
  // Polarity and sampling
  always_comb begin
    // Disabled channel reports low so no stale edge appears
    resD = cif.ctrl[CCL_EN_BIT] & (cif.raw ^ cif.ctrl[CCL_INV_BIT]);
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      resQ <= CCL_RES_RST;
      prevQ <= CCL_RES_RST;
    end else begin
      resQ <= resD;
      prevQ <= resQ;
    end
  end

  // =====================================================================
  // Event selection
  always_comb begin
    evtSel = ccl_evt_t'(cif.ctrl[CCL_EVT_HI:CCL_EVT_LO]);
    rise = resQ & ~prevQ;
    fall = ~resQ & prevQ;
    unique case (evtSel)
      CCL_EVT_NONE: cif.evt = 1'b0;
      CCL_EVT_RISE: cif.evt = rise;
      CCL_EVT_FALL: cif.evt = fall;
      CCL_EVT_ANY: cif.evt = rise | fall;
    endcase
  end

  assign cif.result = resQ;

  chk_plain_level: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (cif.ctrl[CCL_EN_BIT] && !cif.ctrl[CCL_INV_BIT])
      |-> ##1 (cif.result == $past(cif.raw)))
    else $error("plain result does not follow comparator");

  chk_invert_level: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (cif.ctrl[CCL_EN_BIT] && cif.ctrl[CCL_INV_BIT])
      |-> ##1 (cif.result == !$past(cif.raw)))
    else $error("inverted result wrong");

  chk_none_quiet: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (cif.ctrl[CCL_EVT_HI:CCL_EVT_LO] == 2'b00) |-> !cif.evt)
    else $error("event raised with events disabled");

  chk_rise_event: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (cif.ctrl[CCL_EVT_HI:CCL_EVT_LO] == CCL_EVT_RISE && $rose(cif.result))
      |-> cif.evt)
    else $error("rising edge missed");

endmodule // ccl_channel

// file: verilog/ccl_top.sv
`timescale 1ns/1ns
// Function
// - Three channels, each with its own independent control register
// - Control register holds input selection, output and event settings
// - Each channel offers eight input pairings from pins and references
// - Positive input picks A pin or ladder reference by one bit
// - Two-bit field picks negative input: B, C, shared B or bandgap
// - Raw result is high when positive input exceeds negative input
// - Invert clear: status bit high when positive exceeds negative
// - Invert set: status bit high when positive is below negative
// - Status register reports three results, channel 1 in bit 0
// - Status upper five bits read zero; writes to it do nothing
// - Adjusted result is readable and drivable onto a device pin
// - Each channel raises its own event with configurable trigger
// - Enable bit turns the channel on; clear turns it off
// - Output enable puts result on pin; direction still gates driver
// - Event field: 01 rise, 10 fall, 11 any change, 00 none
// - Reset returns all control registers to reset, channels off
module ccl_top (
  input wire logic clk_sys, // System clock, 100 MHz
  input wire logic sys_rst, // Async reset, active high
  input wire logic [7:0] regAddr, // Register address
  input wire logic [7:0] regWrData, // Write data
  input wire logic regWr, // Write strobe
  input wire logic regRd, // Read strobe
  output logic [7:0] regRdData, // Read data, cycle after strobe
  input wire logic [ccl_pkg::CCL_NCH-1:0] rawResult, // Comparator cores
  output logic [ccl_pkg::CCL_NCH-1:0] chanEnable, // Core power on
  output logic [ccl_pkg::CCL_NCH-1:0] posRefSelect, // 1: ladder ref
  output logic [2*ccl_pkg::CCL_NCH-1:0] negInputSelect, // 2 bits each
  input wire logic [ccl_pkg::CCL_NCH-1:0] portData, // Normal port data
  input wire logic [ccl_pkg::CCL_NCH-1:0] pinDirIn, // 1: pin is input
  output logic [ccl_pkg::CCL_NCH-1:0] resultPinOut, // Pin output level
  output logic [ccl_pkg::CCL_NCH-1:0] resultPinOeN, // Low: pin driven
  output logic [ccl_pkg::CCL_NCH-1:0] eventFlag // Sticky event flags
);
  import ccl_pkg::*;

  logic [7:0] ctrlD [CCL_NCH];
  logic [7:0] ctrlQ [CCL_NCH];
  logic [CCL_NCH-1:0] flagD;
  logic [CCL_NCH-1:0] flagQ;
  logic [7:0] rdD;
  logic [7:0] rdQ;
  logic [CCL_NCH-1:0] resultVec;
  logic [CCL_NCH-1:0] evtVec;
  logic flagWr;

  // =====================================================================
  // Control registers
  always_comb begin
    for (int i = 0; i < CCL_NCH; i++) begin
      ctrlD[i] = ctrlQ[i];
      // Each channel decodes only its own address
      if (regWr && regAddr == CCL_ADDR_CTRL1 + 8'(i)) begin
        ctrlD[i] = regWrData;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < CCL_NCH; i++) begin
        ctrlQ[i] <= CCL_CTRL_RST;
      end
    end else begin
      for (int i = 0; i < CCL_NCH; i++) begin
        ctrlQ[i] <= ctrlD[i];
      end
    end
  end

  // =====================================================================
  // Event flags
  always_comb begin
    flagWr = regWr && (regAddr == CCL_ADDR_FLAGS);
    flagD = flagQ;
    // Writing a 1 fakes an event; writing 0 clears
    if (flagWr) begin
      flagD = regWrData[CCL_NCH-1:0];
    end
    // A new event beats a clear in the same cycle
    flagD = flagD | evtVec;
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      flagQ <= CCL_FLAG_RST;
    end else begin
      flagQ <= flagD;
    end
  end

  assign eventFlag = flagQ;

  // =====================================================================
  // Read path
  always_comb begin
    rdD = CCL_RD_ZERO;
    if (regRd) begin
      unique case (regAddr)
        CCL_ADDR_CTRL1: rdD = ctrlQ[0];
        CCL_ADDR_CTRL2: rdD = ctrlQ[1];
        CCL_ADDR_CTRL3: rdD = ctrlQ[2];
        CCL_ADDR_STATUS: rdD = {CCL_STAT_PAD, resultVec};
        CCL_ADDR_FLAGS: rdD = {CCL_STAT_PAD, flagQ};
        default: rdD = CCL_RD_ZERO;
      endcase
    end
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdQ <= CCL_RD_ZERO;
    end else begin
      rdQ <= rdD;
    end
  end

  assign regRdData = rdQ;

  // =====================================================================
  // Channels, analog selects and pins
  for (genvar g = 0; g < CCL_NCH; g++) begin : gen_ch
    ccl_chan_if cif ();

    assign cif.ctrl = ctrlQ[g];
    assign cif.raw = rawResult[g];
    assign resultVec[g] = cif.result;
    assign evtVec[g] = cif.evt;

    ccl_channel u_chan (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .cif(cif)
    );

    assign chanEnable[g] = ctrlQ[g][CCL_EN_BIT];
    // Eight pairings: one positive bit times two negative bits
    assign posRefSelect[g] = ctrlQ[g][CCL_PREF_BIT];
    assign negInputSelect[2*g+1:2*g] =
      ctrlQ[g][CCL_NSEL_HI:CCL_NSEL_LO];
    // Direction bit keeps control of the driver in either mode
    assign resultPinOut[g] =
      ctrlQ[g][CCL_OE_BIT] ? cif.result : portData[g];
    assign resultPinOeN[g] = pinDirIn[g];

    chk_pin_result: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      ctrlQ[g][CCL_OE_BIT] |-> (resultPinOut[g] == resultVec[g]))
      else $error("pin not carrying comparator result");

    chk_pin_port: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      !ctrlQ[g][CCL_OE_BIT] |-> (resultPinOut[g] == portData[g]))
      else $error("pin not carrying port data");

    chk_pin_dir: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (resultPinOeN[g] == pinDirIn[g]))
      else $error("direction bit not gating driver");

    chk_off_low: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (!chanEnable[g])[*2] |-> !resultVec[g])
      else $error("disabled channel shows result");

    chk_flag_sets: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      evtVec[g] |=> eventFlag[g])
      else $error("event did not set flag");

    chk_flag_holds: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (eventFlag[g] && !flagWr) |=> eventFlag[g])
      else $error("flag dropped without software clear");

    chk_flag_clear: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (flagWr && !regWrData[g] && !evtVec[g]) |=> !eventFlag[g])
      else $error("flag not cleared by write of zero");

    chk_write_enable: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (regWr && regAddr == CCL_ADDR_CTRL1 + 8'(g))
        |=> (chanEnable[g] == $past(regWrData[CCL_EN_BIT])))
      else $error("enable bit not applied to core");

    chk_write_pos: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (regWr && regAddr == CCL_ADDR_CTRL1 + 8'(g))
        |=> (posRefSelect[g] == $past(regWrData[CCL_PREF_BIT])))
      else $error("positive input select not applied");

    chk_write_neg: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (regWr && regAddr == CCL_ADDR_CTRL1 + 8'(g))
        |=> (negInputSelect[2*g+1:2*g]
          == $past(regWrData[CCL_NSEL_HI:CCL_NSEL_LO])))
      else $error("negative input select not applied");

    chk_flag_forced: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (flagWr && regWrData[g]) |=> eventFlag[g])
      else $error("written one did not set flag");

    chk_flag_idle: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (!evtVec[g] && !flagWr && !eventFlag[g]) |=> !eventFlag[g])
      else $error("flag set without an event");

    chk_rise_flag: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (ctrlQ[g][CCL_EVT_HI:CCL_EVT_LO] == CCL_EVT_RISE
        && $rose(resultVec[g])) |=> eventFlag[g])
      else $error("rising result did not set flag");

    chk_rise_only: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (ctrlQ[g][CCL_EVT_HI:CCL_EVT_LO] == CCL_EVT_RISE && !flagWr
        && !$rose(resultVec[g]) && !eventFlag[g]) |=> !eventFlag[g])
      else $error("rising mode flagged another change");

    chk_fall_flag: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (ctrlQ[g][CCL_EVT_HI:CCL_EVT_LO] == CCL_EVT_FALL
        && $fell(resultVec[g])) |=> eventFlag[g])
      else $error("falling result did not set flag");

    chk_any_flag: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (ctrlQ[g][CCL_EVT_HI:CCL_EVT_LO] == CCL_EVT_ANY
        && $changed(resultVec[g])) |=> eventFlag[g])
      else $error("changed result did not set flag");

    chk_none_flag: assert property (
      @(posedge clk_sys) disable iff (sys_rst)
      (ctrlQ[g][CCL_EVT_HI:CCL_EVT_LO] == CCL_EVT_NONE && !flagWr
        && !eventFlag[g]) |=> !eventFlag[g])
      else $error("flag set with events disabled");
  end

  // =====================================================================
  // Register behaviour checks
  chk_ctrl_write: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (regWr && regAddr == CCL_ADDR_CTRL2)
      |=> (ctrlQ[1] == $past(regWrData)))
    else $error("control write not stored");

  chk_chan_indep: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (regWr && regAddr == CCL_ADDR_CTRL2)
      |=> ($stable(ctrlQ[0]) && $stable(ctrlQ[2])))
    else $error("write touched another channel");

  chk_status_read: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (regRd && regAddr == CCL_ADDR_STATUS)
      |=> (regRdData[2:0] == $past(resultVec)))
    else $error("status read wrong");

  chk_status_pad: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (regRd && regAddr == CCL_ADDR_STATUS) |=> (regRdData[7:3] == 5'h00))
    else $error("status upper bits not zero");

  chk_status_ro: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (regWr && regAddr == CCL_ADDR_STATUS)
      |=> ($stable(ctrlQ[0]) && $stable(ctrlQ[1]) && $stable(ctrlQ[2])))
    else $error("status write changed state");

  chk_read_one: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    !regRd |=> (regRdData == 8'h00))
    else $error("read data outside its cycle");

  chk_reset_off: assert property (
    @(posedge clk_sys)
    $past(sys_rst) |-> (ctrlQ[0] == CCL_CTRL_RST && chanEnable == 3'h0))
    else $error("channels not off after reset");

  chk_reset_all: assert property (
    @(posedge clk_sys)
    $past(sys_rst) |-> (ctrlQ[1] == CCL_CTRL_RST
      && ctrlQ[2] == CCL_CTRL_RST && eventFlag == CCL_FLAG_RST))
    else $error("state not at reset value after reset");

  chk_ctrl_read: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (regRd && regAddr == CCL_ADDR_CTRL1)
      |=> (regRdData == $past(ctrlQ[0])))
    else $error("control read wrong");

  chk_flag_read: assert property (
    @(posedge clk_sys) disable iff (sys_rst)
    (regRd && regAddr == CCL_ADDR_FLAGS)
      |=> (regRdData == {CCL_STAT_PAD, $past(eventFlag)}))
    else $error("flag read wrong");

endmodule // ccl_top

// file: sim/ccl_core_model.sv
`timescale 1ns/1ns
// ====================
// Analog comparator cores, behavioural
module ccl_core_model (
  input wire logic clk_sys, // System clock
  input wire logic [2:0] chanEnable, // Core power
  input wire logic [2:0] posRefSelect, // 1: ladder
  input wire logic [5:0] negInputSelect, // 2 bits each
  input wire logic [23:0] vA, // A pins
  input wire logic [23:0] vB, // B pins
  input wire logic [23:0] vC, // C pins
  input wire logic [7:0] vLad, // Ladder ref
  input wire logic [7:0] vSb, // Shared B pin
  input wire logic [7:0] bandgap_reference, // Bandgap
  output logic [2:0] rawResult // Core outputs
);
  logic [7:0] p;
  logic [7:0] n;
  logic [2:0] junk = 3'h0;
  // Unpowered core output means nothing; keep it moving
  always @(posedge clk_sys) junk <= ~junk;
  always_comb begin
    p = 8'h00;
    n = 8'h00;
    for (int i = 0; i < 3; i++) begin
      p = posRefSelect[i] ? vLad : vA[8*i +: 8];
      case (negInputSelect[2*i +: 2])
        2'b00: n = vSb;
        2'b01: n = vB[8*i +: 8];
        2'b10: n = vC[8*i +: 8];
        default: n = bandgap_reference;
      endcase
      rawResult[i] = chanEnable[i] ? (p > n) : junk[i];
    end
  end
endmodule // ccl_core_model

// file: sim/test_ccl_top.sv
`timescale 1ns/1ns
module test_ccl_top;
  import ccl_pkg::*;
  typedef struct {string nm; logic [7:0] v;} ccl_exp_t;
  logic clk_sys, sys_rst, regWr, regRd;
  logic [7:0] regAddr, regWrData, regRdData, vLad, vSb, bandgap_reference;
  logic [2:0] rawResult, chanEnable, posRefSelect, portData, pinDirIn;
  logic [2:0] resultPinOut, resultPinOeN, eventFlag;
  logic [5:0] negInputSelect;
  logic [23:0] vA, vB, vC;
  logic [7:0] ctl [3];
  ccl_exp_t q [$];
  int n_fail = 0;
  int comparisons = 0;
  logic pend = 1'b0;

  ccl_top DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .rawResult(rawResult), .chanEnable(chanEnable),
    .posRefSelect(posRefSelect), .negInputSelect(negInputSelect),
    .portData(portData), .pinDirIn(pinDirIn), .resultPinOut(resultPinOut),
    .resultPinOeN(resultPinOeN), .eventFlag(eventFlag));
  ccl_core_model core (.clk_sys(clk_sys), .chanEnable(chanEnable),
    .posRefSelect(posRefSelect), .negInputSelect(negInputSelect), .vA(vA),
    .vB(vB), .vC(vC), .vLad(vLad), .vSb(vSb), .bandgap_reference(bandgap_reference),
    .rawResult(rawResult));

  // ====================
  // Bus tasks and checking
  task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic acc(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge clk_sys);
    regWr <= w;
    regRd <= !w;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
    regRd <= 1'b0;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    if (a < 8'h03) ctl[a] = d;
    acc(1'b1, a, d);
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e, string nm);
    q.push_back('{nm, e});
    acc(1'b0, a, 8'h00);
  endtask
  // Data of a read taken at one edge is seen at the next
  always @(posedge clk_sys) begin
    ccl_exp_t x;
    if (pend) begin
      if (q.size() == 0) chk("readq", 8'h00, 8'hff);
      else begin
        x = q.pop_front();
        chk(x.nm, x.v, regRdData);
      end
    end
    pend = regRd;
  end
  function automatic logic adj(int i);
    logic [7:0] p, n;
    p = ctl[i][2] ? vLad : vA[8*i +: 8];
    case (ctl[i][1:0])
      2'b00: n = vSb;
      2'b01: n = vB[8*i +: 8];
      2'b10: n = vC[8*i +: 8];
      default: n = bandgap_reference;
    endcase
    return ctl[i][7] & ((p > n) ^ ctl[i][5]);
  endfunction
  task automatic chkStat();
    logic [2:0] s;
    for (int i = 0; i < 3; i++) s[i] = adj(i);
    rd(CCL_ADDR_STATUS, {5'h00, s}, "status");
    #1;
    for (int i = 0; i < 3; i++) begin
      chk("pin", ctl[i][6] ? s[i] : portData[i], resultPinOut[i]);
      chk("pinOeN", pinDirIn[i], resultPinOeN[i]);
      chk("coreEn", ctl[i][7], chanEnable[i]);
      chk("posSel", ctl[i][2], posRefSelect[i]);
      chk("negSel", ctl[i][1:0], negInputSelect[2*i +: 2]);
    end
  endtask
  task automatic summarize();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ====================
  // Stimulus
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    chk("timeout", 8'h00, 8'h01);
    summarize();
  end
  initial begin
    void'($urandom(32'h0963));
    sys_rst = 1'b1;
    {regWr, regRd, regAddr, regWrData, portData, pinDirIn} = '0;
    {vA, vB, vC, vLad, vSb, bandgap_reference} = '0;
    repeat (10) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      ctl[i] = 8'h1f;
      rd(8'(i), 8'h1f, "ctrlRst");
    end
    rd(CCL_ADDR_FLAGS, 8'h00, "flagRst");
    chkStat();
    // Positives even, negatives odd: never equal, so results are defined
    repeat (12) begin
      vA <= 24'($urandom()) & 24'hfefefe;
      vB <= 24'($urandom()) | 24'h010101;
      vC <= 24'($urandom()) | 24'h010101;
      vLad <= 8'($urandom()) & 8'hfe;
      vSb <= 8'($urandom()) | 8'h01;
      bandgap_reference <= 8'($urandom()) | 8'h01;
      portData <= 3'($urandom());
      pinDirIn <= 3'($urandom());
      for (int i = 0; i < 3; i++) wr(8'(i), 8'($urandom()));
      for (int i = 0; i < 3; i++) rd(8'(i), ctl[i], "ctrl");
      chkStat();
    end
    wr(CCL_ADDR_STATUS, 8'hff);
    chkStat();
    // Inputs are static here, so only software touches the flags
    wr(CCL_ADDR_FLAGS, 8'h07);
    rd(CCL_ADDR_FLAGS, 8'h07, "flagSet");
    wr(CCL_ADDR_FLAGS, 8'h00);
    rd(CCL_ADDR_FLAGS, 8'h00, "flagZero");
    rd(8'h07, 8'h00, "unmapped");
    for (int k = 0; k < 16; k++) begin
      int c;
      logic up, inv, hit;
      logic [1:0] m;
      c = k % 3;
      m = k[3:2];
      inv = k[1];
      up = k[0];
      vB[8*c +: 8] <= 8'h81;
      vA[8*c +: 8] <= up ? 8'h10 : 8'hf0;
      wr(8'(c), {2'b11, inv, m, 3'b001});
      repeat (3) @(posedge clk_sys);
      wr(CCL_ADDR_FLAGS, 8'h00);
      rd(CCL_ADDR_FLAGS, 8'h00, "flagClr");
      vA[8*c +: 8] <= up ? 8'hf0 : 8'h10;
      hit = (m == 2'b11) || (m == 2'b01 && (up ^ inv)) ||
        (m == 2'b10 && !(up ^ inv));
      repeat (4) @(posedge clk_sys);
      #1;
      chk("flagOut", 8'(hit), 8'(eventFlag[c]));
      rd(CCL_ADDR_FLAGS, {5'h00, 3'(hit) << c}, "flag");
      chkStat();
    end
    // Reset in mid-run must undo every written control register
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (int i = 0; i < 3; i++) begin
      ctl[i] = 8'h1f;
      rd(8'(i), 8'h1f, "ctrlRst2");
    end
    rd(CCL_ADDR_FLAGS, 8'h00, "flagRst2");
    chkStat();
    repeat (3) @(posedge clk_sys);
    if (q.size() != 0) chk("pending", 8'h00, 8'(q.size()));
    summarize();
  end
endmodule // test_ccl_top
